/* File: tac_cc_unit.sv */
// Compare side of one capture/compare unit: special event on a period match.
`timescale 1ns/1ns
module tac_cc_unit (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [15:0] count,
  input wire logic baseValid,
  input tac_pkg::tac_cc_cfg_t cfg,
  output logic specialEvent
);
  logic matchNow;
  logic matchPrev_ff;
  logic event_ff;

  // Match only in special-event mode and only with a usable time base.
  assign matchNow = baseValid && (cfg.mode == tac_pkg::MODE_SPECIAL_EVENT) // RQ10 RQ3
    && (count == cfg.value); // RQ14

  // One pulse per arrival at the compare value, not one per cycle held.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      matchPrev_ff <= 1'b0;
      event_ff <= 1'b0;
    end else begin
      matchPrev_ff <= matchNow;
      event_ff <= matchNow & ~matchPrev_ff;
    end
  end

  assign specialEvent = event_ff;
endmodule : tac_cc_unit

/* File: tac_clk_src.sv */
// Behavioural external count clock and low-frequency crystal at the timer's pins.
`timescale 1ns/1ns
module tac_clk_src (
  input wire logic extRun,
  input wire logic oscOutEn,
  output logic extClkPin,
  output logic osc_in_pin,
  output logic [15:0] edgeCount
);
  // External source pulses at its own phase only while asked to run, counting its rising edges.
  initial begin
    extClkPin = 1'b0;
    edgeCount = 16'h0000;
    forever begin
      #730;
      if (extRun) begin
        extClkPin = 1'b1;
        edgeCount = edgeCount + 16'h0001;
        #730;
      end
      extClkPin = 1'b0;
    end
  end
  // The crystal swings only while its amplifier is enabled, asleep or not.
  initial begin
    osc_in_pin = 1'b0;
    forever begin
      #1550;
      osc_in_pin = oscOutEn ? ~osc_in_pin : 1'b0;
    end
  end
endmodule : tac_clk_src

/* File: tac_edge_det.sv */
// Rising-edge detector with an optional synchronizer chain in front.
`timescale 1ns/1ns
module tac_edge_det #(
  parameter int STAGES = 2
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic din,
  output logic risePulse
);
  logic [STAGES-1:0] chain_ff;
  logic [STAGES:0] chainIn;
  logic last_ff;

  // New sample enters at the bottom, so a single-stage chain needs no special case.
  assign chainIn = {chain_ff, din};

  // Shift the input through the chain; only the last stage feeds the detector.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      chain_ff <= '0;
      last_ff <= 1'b0;
    end else begin
      chain_ff <= chainIn[STAGES-1:0];
      last_ff <= chain_ff[STAGES-1];
    end
  end

  // A rise is a high last stage after a low one.
  assign risePulse = chain_ff[STAGES-1] & ~last_ff;
endmodule : tac_edge_det

/* File: tac_pkg.sv */
// Shared constants and types for the asynchronous-capable timer block.
// What this block and its software must do
// RQ1: Bypass bit set: count external clock unsynchronized.
// RQ2: Unsynchronized counting runs in sleep, overflow wakes.
// RQ3: Asynchronous counting withholds time base from compares.
// RQ4: Count byte reads always return stable values.
// RQ5: Software compensates overflow between two byte reads.
// RQ6: Software stops timer before writing the count.
// RQ7: Crystal amplifier drives only while enable bit set.
// RQ8: Enabled crystal oscillator keeps running during sleep.
// RQ9: Software waits for oscillator start-up before use.
// RQ10: Compare special-event mode trigger resets the count.
// RQ11: Trigger reset never sets the overflow flag.
// RQ12: Trigger reset honoured only in synchronous modes.
// RQ13: Software count write beats a same-cycle trigger.
// RQ14: Compare value pair acts as the timer period.
// RQ15: Rollover from maximum to zero sets overflow flag.
package tac_pkg;
  // Register addresses on the plain register port.
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_CNT_LO = 4'h1;
  localparam logic [3:0] ADDR_CNT_HI = 4'h2;
  localparam logic [3:0] ADDR_FLAG = 4'h3;
  localparam logic [3:0] ADDR_CCA_LO = 4'h4;
  localparam logic [3:0] ADDR_CCA_HI = 4'h5;
  localparam logic [3:0] ADDR_CCA_MODE = 4'h6;
  localparam logic [3:0] ADDR_CCB_LO = 4'h7;
  localparam logic [3:0] ADDR_CCB_HI = 4'h8;
  localparam logic [3:0] ADDR_CCB_MODE = 4'h9;
  // Control register bit positions.
  localparam int CTRL_RUN = 0;
  localparam int CTRL_EXT_SEL = 1;
  localparam int CTRL_SYNC_BYPASS_N = 2;
  localparam int CTRL_OSC_EN = 3;
  localparam int CTRL_OVF_IE = 4;
  localparam int CTRL_WIDTH = 5;
  // Flag register bit position.
  localparam int FLAG_OVF = 0;
  // Reset values and the count maximum.
  localparam logic [4:0] CTRL_RESET = 5'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [3:0] MODE_RESET = 4'h0;
  // Compare mode code that issues the special event trigger.
  localparam logic [3:0] MODE_SPECIAL_EVENT = 4'hB;
  // Core clock and instruction-cycle rate.
  localparam int CLK_SYS_HZ = 10_000_000;
  localparam int INSTR_HZ = 2_500_000;
  localparam int INSTR_DIV = CLK_SYS_HZ / INSTR_HZ;
  // Settings of one capture/compare unit.
  typedef struct packed {
    logic [3:0] mode;
    logic [15:0] value;
  } tac_cc_cfg_t;
  // One register-port request.
  typedef struct packed {
    logic wrStb;
    logic rdStb;
    logic [3:0] addr;
    logic [7:0] wrData;
  } tac_reg_req_t;
endpackage : tac_pkg

/* File: tac_timer.sv */
// Sixteen-bit timer/counter with sync and async counting, crystal and trigger reset.
//
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ns
module tac_timer (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  output logic [7:0] regRdData,
  input wire logic sleepMode,
  input wire logic extClkPin,
  input wire logic osc_in_pin,
  output logic osc_out_pin,
  output logic oscOutEn,
  output logic timeBaseValid,
  output logic [15:0] timeBase,
  output logic ccEventA,
  output logic ccEventB,
  output logic wakeIrq
);
  tac_pkg::tac_reg_req_t req;
  logic [tac_pkg::CTRL_WIDTH-1:0] timer_control_reg_ff;
  logic [15:0] count_ff;
  logic [15:0] nxt_count;
  logic overflow_irq_flag_ff;
  logic nxt_overflowFlag;
  tac_pkg::tac_cc_cfg_t cc_unit_a_ff;
  tac_pkg::tac_cc_cfg_t cc_unit_b_ff;
  logic [7:0] rdData_ff;
  logic [7:0] rdMux;
  logic wakeIrq_ff;
  logic [1:0] instrDiv_ff;
  logic instrTick;
  logic runOn;
  logic extSel;
  logic sync_bypass_n;
  logic osc_enable_bit;
  logic ovfIrqEn;
  logic asyncMode;
  logic countSrc;
  logic syncRise;
  logic asyncRise;
  logic countTick;
  logic wrCtrl;
  logic wrCntLo;
  logic wrCntHi;
  logic wrCount;
  logic wrFlag;
  logic trigA;
  logic trigB;
  logic trigReset;
  logic rollover;

  // Bundle the register-port request.
  assign req.wrStb = regWrStb;
  assign req.rdStb = regRdStb;
  assign req.addr = regAddr;
  assign req.wrData = regWrData;

  // Control bit fields.
  assign runOn = timer_control_reg_ff[tac_pkg::CTRL_RUN];
  assign extSel = timer_control_reg_ff[tac_pkg::CTRL_EXT_SEL];
  assign sync_bypass_n = timer_control_reg_ff[tac_pkg::CTRL_SYNC_BYPASS_N];
  assign osc_enable_bit = timer_control_reg_ff[tac_pkg::CTRL_OSC_EN];
  assign ovfIrqEn = timer_control_reg_ff[tac_pkg::CTRL_OVF_IE];
  assign asyncMode = extSel && sync_bypass_n; // RQ1

  // Write decode.
  assign wrCtrl = req.wrStb && (req.addr == tac_pkg::ADDR_CTRL);
  assign wrCntLo = req.wrStb && (req.addr == tac_pkg::ADDR_CNT_LO);
  assign wrCntHi = req.wrStb && (req.addr == tac_pkg::ADDR_CNT_HI);
  assign wrFlag = req.wrStb && (req.addr == tac_pkg::ADDR_FLAG);
  assign wrCount = wrCntLo || wrCntHi;

  // Crystal amplifier: inverts the crystal input and drives only when enabled.
  // Sleep does not gate it, so the oscillator keeps running while asleep.
  assign osc_out_pin = osc_enable_bit & ~osc_in_pin; // RQ7 RQ8
  assign oscOutEn = osc_enable_bit; // RQ7

  // External count clock comes from the crystal when it runs, else the pin.
  assign countSrc = osc_enable_bit ? osc_in_pin : extClkPin;

  // Synchronized path: two-stage synchronizer, then edge detect.
  tac_edge_det #(
    .STAGES(2)
  ) u_syncEdge (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .din(countSrc),
    .risePulse(syncRise)
  );

  // Bypass path: a single sample stage, no synchronizer chain.
  tac_edge_det #(
    .STAGES(1)
  ) u_asyncEdge (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .din(countSrc),
    .risePulse(asyncRise)
  );

  // Instruction-cycle enable: one pulse every INSTR_DIV core clocks.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      instrDiv_ff <= 2'h0;
    end else if (instrTick) begin
      instrDiv_ff <= 2'h0;
    end else begin
      instrDiv_ff <= instrDiv_ff + 2'h1;
    end
  end
  assign instrTick = (instrDiv_ff == 2'(tac_pkg::INSTR_DIV - 1));

  // Count enable. Internal and synchronized sources stop in sleep;
  // the bypass path keeps counting while the core sleeps.
  assign countTick = runOn && (extSel
    ? (sync_bypass_n ? asyncRise : (syncRise && !sleepMode)) // RQ1 RQ2
    : (instrTick && !sleepMode));

  // Time base offered to the compare units only when not counting asynchronously.
  assign timeBaseValid = !asyncMode; // RQ3
  assign timeBase = asyncMode ? tac_pkg::COUNT_RESET : count_ff; // RQ3

  tac_cc_unit u_ccA (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .count(count_ff),
    .baseValid(timeBaseValid),
    .cfg(cc_unit_a_ff),
    .specialEvent(trigA)
  );

  tac_cc_unit u_ccB (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .count(count_ff),
    .baseValid(timeBaseValid),
    .cfg(cc_unit_b_ff),
    .specialEvent(trigB)
  );

  assign ccEventA = trigA;
  assign ccEventB = trigB;

  // Either unit's trigger restarts the count, but never in async counting.
  assign trigReset = (trigA || trigB) && !asyncMode; // RQ10 RQ12 RQ14

  // Rollover happens only on a real increment from the maximum.
  assign rollover = countTick && !wrCount && !trigReset && (count_ff == tac_pkg::COUNT_MAX); // RQ15 RQ11

  // Next count: software write first, then trigger reset, then increment.
  assign nxt_count = wrCntLo ? {count_ff[15:8], req.wrData}
    : wrCntHi ? {req.wrData, count_ff[7:0]} // RQ13
    : trigReset ? tac_pkg::COUNT_RESET // RQ10
    : countTick ? count_ff + 16'h0001
    : count_ff;

  // Overflow flag: hardware set beats a software clear in the same cycle.
  assign nxt_overflowFlag = rollover ? 1'b1 // RQ15
    : wrFlag ? req.wrData[tac_pkg::FLAG_OVF]
    : overflow_irq_flag_ff;

  // Count and flag storage.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      count_ff <= tac_pkg::COUNT_RESET;
      overflow_irq_flag_ff <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      overflow_irq_flag_ff <= nxt_overflowFlag;
    end
  end

  // Control and compare configuration registers.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      timer_control_reg_ff <= tac_pkg::CTRL_RESET;
      cc_unit_a_ff <= '{mode: tac_pkg::MODE_RESET, value: tac_pkg::COUNT_RESET};
      cc_unit_b_ff <= '{mode: tac_pkg::MODE_RESET, value: tac_pkg::COUNT_RESET};
    end else if (req.wrStb) begin
      unique case (req.addr)
        tac_pkg::ADDR_CTRL: timer_control_reg_ff <= req.wrData[tac_pkg::CTRL_WIDTH-1:0];
        tac_pkg::ADDR_CCA_LO: cc_unit_a_ff.value[7:0] <= req.wrData;
        tac_pkg::ADDR_CCA_HI: cc_unit_a_ff.value[15:8] <= req.wrData;
        tac_pkg::ADDR_CCA_MODE: cc_unit_a_ff.mode <= req.wrData[3:0];
        tac_pkg::ADDR_CCB_LO: cc_unit_b_ff.value[7:0] <= req.wrData;
        tac_pkg::ADDR_CCB_HI: cc_unit_b_ff.value[15:8] <= req.wrData;
        tac_pkg::ADDR_CCB_MODE: cc_unit_b_ff.mode <= req.wrData[3:0];
        default: begin
        end
      endcase
    end
  end

  // Read selection. Count bytes come from the core-clock register, so a byte
  // read is always a settled value even while counting asynchronously.
  assign rdMux = (req.addr == tac_pkg::ADDR_CTRL) ? {3'h0, timer_control_reg_ff}
    : (req.addr == tac_pkg::ADDR_CNT_LO) ? count_ff[7:0] // RQ4
    : (req.addr == tac_pkg::ADDR_CNT_HI) ? count_ff[15:8] // RQ4
    : (req.addr == tac_pkg::ADDR_FLAG) ? {7'h00, overflow_irq_flag_ff}
    : (req.addr == tac_pkg::ADDR_CCA_LO) ? cc_unit_a_ff.value[7:0]
    : (req.addr == tac_pkg::ADDR_CCA_HI) ? cc_unit_a_ff.value[15:8]
    : (req.addr == tac_pkg::ADDR_CCA_MODE) ? {4'h0, cc_unit_a_ff.mode}
    : (req.addr == tac_pkg::ADDR_CCB_LO) ? cc_unit_b_ff.value[7:0]
    : (req.addr == tac_pkg::ADDR_CCB_HI) ? cc_unit_b_ff.value[15:8]
    : (req.addr == tac_pkg::ADDR_CCB_MODE) ? {4'h0, cc_unit_b_ff.mode}
    : 8'h00;

  // Read data and wake request registers; read data stands one cycle only.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rdData_ff <= 8'h00;
      wakeIrq_ff <= 1'b0;
    end else begin
      rdData_ff <= req.rdStb ? rdMux : 8'h00;
      wakeIrq_ff <= overflow_irq_flag_ff && ovfIrqEn; // RQ2
    end
  end

  assign regRdData = rdData_ff;
  assign wakeIrq = wakeIrq_ff;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  flag_on_roll_a: assert property ( // RQ15
    (runOn && countTick && count_ff == 16'hFFFF && !wrCount && !trigReset)
      |=> (overflow_irq_flag_ff && count_ff == 16'h0000))
    else $error("Rollover did not set the overflow flag.");

  trig_no_flag_a: assert property ( // RQ11
    (trigReset && !wrCount && !overflow_irq_flag_ff && !wrFlag) |=> !overflow_irq_flag_ff)
    else $error("Trigger reset raised the overflow flag.");

  trig_resets_a: assert property ( // RQ10
    (trigReset && !wrCount) |=> (count_ff == 16'h0000))
    else $error("Trigger did not clear the count.");

  write_wins_a: assert property ( // RQ13
    (wrCntLo && trigReset) |=> (count_ff[7:0] == $past(regWrData) && count_ff[15:8] == $past(count_ff[15:8])))
    else $error("Trigger overrode a count write.");

  async_no_base_a: assert property ( // RQ3
    asyncMode |-> (!timeBaseValid && timeBase == 16'h0000))
    else $error("Async count offered as a time base.");

  async_no_reset_a: assert property ( // RQ12
    (asyncMode && !wrCount && !countTick) |=> (count_ff == $past(count_ff)))
    else $error("Count changed without cause in async mode.");

  sleep_counts_a: assert property ( // RQ2
    (sleepMode && asyncMode && runOn && asyncRise && !wrCount && count_ff != 16'hFFFF)
      |=> (count_ff == $past(count_ff) + 16'h0001))
    else $error("Async count stalled during sleep.");

  sleep_sync_stop_a: assert property ( // RQ1
    (sleepMode && !asyncMode && !wrCount && !trigReset) |=> (count_ff == $past(count_ff)))
    else $error("Synchronous count advanced during sleep.");

  osc_gate_a: assert property ( // RQ7
    !osc_enable_bit |-> (!oscOutEn && !osc_out_pin))
    else $error("Oscillator driven while disabled.");

  read_byte_a: assert property ( // RQ4
    (regRdStb && regAddr == tac_pkg::ADDR_CNT_HI) |=> (regRdData == $past(count_ff[15:8])))
    else $error("High count byte read mismatch.");

  wake_follow_a: assert property ( // RQ2
    (overflow_irq_flag_ff && ovfIrqEn) |=> wakeIrq)
    else $error("Wake request missing after overflow.");

  // Read data, control writes, event pulses, the offered time base, the crystal in sleep and the wake line.
  read_low_a: assert property ( // RQ4
    (regRdStb && regAddr == tac_pkg::ADDR_CNT_LO) |=> (regRdData == $past(count_ff[7:0])))
    else $error("Low count byte read mismatch.");

  read_idle_a: assert property ( // RQ4
    !regRdStb |=> (regRdData == 8'h00))
    else $error("Read data stood outside its cycle.");

  ctrl_write_a: assert property ( // RQ7
    wrCtrl |=> (timer_control_reg_ff == $past(regWrData[tac_pkg::CTRL_WIDTH-1:0])))
    else $error("Control write did not land.");

  pulse_a_once_a: assert property ( // RQ10
    ccEventA |=> !ccEventA)
    else $error("Unit A event held longer than one cycle.");

  pulse_b_once_a: assert property ( // RQ10
    ccEventB |=> !ccEventB)
    else $error("Unit B event held longer than one cycle.");

  base_offered_a: assert property ( // RQ3
    !asyncMode |-> (timeBaseValid && timeBase == count_ff))
    else $error("Time base withheld outside async counting.");

  osc_sleep_a: assert property ( // RQ8
    (osc_enable_bit && sleepMode) |-> oscOutEn)
    else $error("Oscillator stopped during sleep.");

  wake_drop_a: assert property ( // RQ2
    !(overflow_irq_flag_ff && ovfIrqEn) |=> !wakeIrq)
    else $error("Wake request without a pending overflow.");
endmodule : tac_timer

/* File: tb_tac_timer.sv */
// Self-checking bench for the sixteen-bit timer with its clock source model.
`timescale 1ns/1ns
module tb_tac_timer;
  logic clk_sys;
  logic arst_n;
  logic [3:0] regAddr;
  logic [7:0] regWrData;
  logic regWrStb;
  logic regRdStb;
  logic [7:0] regRdData;
  logic sleepMode;
  logic extClkPin;
  logic osc_in_pin;
  logic osc_out_pin;
  logic oscOutEn;
  logic timeBaseValid;
  logic [15:0] timeBase;
  logic ccEventA;
  logic ccEventB;
  logic wakeIrq;
  logic extRun;
  logic [15:0] edgeCount;
  logic [15:0] startEdges;
  logic [15:0] ccVal;
  logic [7:0] rdVal;
  logic [7:0] hiVal;
  logic [7:0] wrVal;
  logic [3:0] base;
  logic evSeen;
  int nErrors;
  int nTests;
  int k;

  tac_timer tac_timer_i (.clk_sys(clk_sys), .arst_n(arst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
    .sleepMode(sleepMode), .extClkPin(extClkPin), .osc_in_pin(osc_in_pin),
    .osc_out_pin(osc_out_pin), .oscOutEn(oscOutEn), .timeBaseValid(timeBaseValid),
    .timeBase(timeBase), .ccEventA(ccEventA), .ccEventB(ccEventB), .wakeIrq(wakeIrq));
  tac_clk_src tac_clk_src_i (.extRun(extRun), .oscOutEn(oscOutEn), .extClkPin(extClkPin),
    .osc_in_pin(osc_in_pin), .edgeCount(edgeCount));

  // Core clock at 10 MHz.
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // Compares one value and reports a difference at once.
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    nTests = nTests + 1;
    if (got !== exp) begin
      nErrors = nErrors + 1;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // One-cycle register write.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge clk_sys);
    regWrStb <= 1'b0;
  endtask : wr

  // One-cycle register read; the data stand only in the following cycle.
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge clk_sys);
    regRdStb <= 1'b0;
    @(negedge clk_sys);
    d = regRdData;
  endtask : rd

  // Stops the timer before loading a new count, so no increment can collide.
  task automatic setCount(input logic [15:0] v);
    wr(tac_pkg::ADDR_CTRL, 8'h00);
    wr(tac_pkg::ADDR_CNT_LO, v[7:0]);
    wr(tac_pkg::ADDR_CNT_HI, v[15:8]);
  endtask : setCount

  // Prints the counts and the verdict, then ends the run.
  task automatic results;
    $display("Comparisons %0d, mismatches %0d", nTests, nErrors);
    if (nErrors == 0 && nTests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results

  // Main sequence: reset values, trigger reset, asynchronous counting, crystal.
  initial begin
    nErrors = 0;
    nTests = 0;
    arst_n = 1'b0;
    regAddr = 4'h0;
    regWrData = 8'h00;
    regWrStb = 1'b0;
    regRdStb = 1'b0;
    sleepMode = 1'b0;
    extRun = 1'b0;
    void'($urandom(31));
    repeat (16) @(posedge clk_sys);
    arst_n <= 1'b1;
    // Reset values and an unmapped address all read as zero.
    for (k = 0; k < 5; k++) begin
      rd(k == 4 ? 4'hA : 4'(k), rdVal);
      check(rdVal, 8'h00);
    end
    check(oscOutEn, 1'b0);
    // Trigger reset over both units, internal and synchronized counting, with write collisions.
    for (k = 0; k < 4; k++) begin
      setCount(16'h0000);
      ccVal = 16'h0010 + 16'($urandom % 32);
      wrVal = 8'h80 | 8'($urandom);
      base = k[0] ? tac_pkg::ADDR_CCB_LO : tac_pkg::ADDR_CCA_LO;
      wr(base, ccVal[7:0]);
      wr(base + 4'h1, ccVal[15:8]);
      wr(base + 4'h2, {4'h0, tac_pkg::MODE_SPECIAL_EVENT});
      extRun <= k[1];
      wr(tac_pkg::ADDR_CTRL, k[1] ? 8'h03 : 8'h01);
      evSeen = 1'b0;
      for (int i = 0; i < 1000 && !evSeen; i++) begin
        @(negedge clk_sys);
        evSeen = (timeBase === ccVal);
      end
      if (!evSeen) begin
        nErrors = nErrors + 1;
        results();
      end
      if (k[0] ^ k[1]) begin
        @(posedge clk_sys);
        regAddr <= tac_pkg::ADDR_CNT_LO;
        regWrData <= wrVal;
        regWrStb <= 1'b1;
      end
      @(negedge clk_sys);
      check(k[0] ? ccEventB : ccEventA, 1'b1);
      if (k[0] ^ k[1]) begin
        @(posedge clk_sys);
        regWrStb <= 1'b0;
      end
      @(negedge clk_sys);
      check(timeBase, (k[0] ^ k[1]) ? {8'h00, wrVal} : 16'h0000);
      rd(tac_pkg::ADDR_FLAG, rdVal);
      check(rdVal, 8'h00);
      wr(base + 4'h2, 8'h00);
      extRun <= 1'b0;
    end
    // Asynchronous counting through sleep, across rollover, with a trigger armed.
    setCount(16'hfff0);
    wr(tac_pkg::ADDR_CCA_LO, 8'h02);
    wr(tac_pkg::ADDR_CCA_HI, 8'h00);
    wr(tac_pkg::ADDR_CCA_MODE, {4'h0, tac_pkg::MODE_SPECIAL_EVENT});
    startEdges = edgeCount;
    wr(tac_pkg::ADDR_CTRL, 8'h17);
    @(negedge clk_sys);
    check(timeBaseValid, 1'b0);
    check(timeBase, 16'h0000);
    @(posedge clk_sys);
    sleepMode <= 1'b1;
    extRun <= 1'b1;
    repeat (400) @(posedge clk_sys);
    @(negedge clk_sys);
    check(wakeIrq, 1'b1);
    @(posedge clk_sys);
    extRun <= 1'b0;
    sleepMode <= 1'b0;
    repeat (30) @(posedge clk_sys);
    rd(tac_pkg::ADDR_CNT_LO, rdVal);
    rd(tac_pkg::ADDR_CNT_HI, hiVal);
    check({hiVal, rdVal}, 16'hfff0 + (edgeCount - startEdges));
    rd(tac_pkg::ADDR_FLAG, rdVal);
    check(rdVal, 8'h01);
    wr(tac_pkg::ADDR_CCA_MODE, 8'h00);
    // Crystal runs only when enabled and keeps the count moving in sleep.
    wr(tac_pkg::ADDR_CTRL, 8'h08);
    @(negedge clk_sys);
    check(oscOutEn, 1'b1);
    repeat (100) @(negedge clk_sys);
    check(osc_out_pin, {15'h0000, ~osc_in_pin});
    setCount(16'h0000);
    check(osc_out_pin, 1'b0);
    wr(tac_pkg::ADDR_CTRL, 8'h0f);
    repeat (100) @(posedge clk_sys);
    sleepMode <= 1'b1;
    repeat (200) @(posedge clk_sys);
    sleepMode <= 1'b0;
    rd(tac_pkg::ADDR_CNT_LO, rdVal);
    check(16'(rdVal > 8'h04), 16'h0001);
    results();
  end
endmodule : tb_tac_timer
